// ===== occ_cfg.sv
// configuration register file of the output path with AXI4-Lite slave,
// driving mode outputs, filter coefficients and the output code selector.
// assumes fault_in arrives asynchronously; raw_code is on clk.
`timescale 1ns/1ns
module occ_cfg (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // output path
  input wire logic [15:0] raw_code,
  input wire logic fault_in,
  output logic [15:0] out_code,
  // mode outputs
  output logic write_locked,
  output logic output_filter_cap_pin,
  output logic analog_diag_global_on,
  output logic high_offset_lin,
  output logic [2:0] temp_source_current_setting,
  // filter coefficients
  output logic [15:0] lowpass_coef_k0,
  output logic [15:0] lowpass_coef_k1,
  output logic [15:0] lowpass_coef_k2,
  output logic [15:0] lowpass_coef_m1
);

  // whole state of the block in one record
  typedef struct packed {
    // captured write address and data
    logic aw_held;
    logic [31:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // answers on the bus
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // stored settings
    logic [7:0] mode;
    logic [7:0] fault_hi;
    logic [7:0] k0_hi;
    logic [15:0] k1;
    logic [15:0] k2;
    logic [15:0] m1;
    logic [11:0] floor_v;
    logic [11:0] ceil_v;
    logic [11:0] clamp_lo;
    logic [11:0] clamp_hi;
    // two-stage synchroniser of the fault pin
    logic [1:0] fault_sync;
  } occ_cfg_state_t;

  occ_cfg_state_t s_r;
  occ_cfg_state_t s_nxt;

  logic fault_active;
  logic below;
  logic above;

  // map a byte address onto a register
  // addresses outside the map fall to REG_NONE and answer an error
  function automatic occ_pkg::occ_reg_t decode(input logic [31:0] a);
    case (a)
      occ_pkg::ADR_MODE: decode = occ_pkg::REG_MODE;
      occ_pkg::ADR_FAULT: decode = occ_pkg::REG_FAULT;
      occ_pkg::ADR_K0: decode = occ_pkg::REG_K0;
      occ_pkg::ADR_K1: decode = occ_pkg::REG_K1;
      occ_pkg::ADR_K2: decode = occ_pkg::REG_K2;
      occ_pkg::ADR_M1: decode = occ_pkg::REG_M1;
      occ_pkg::ADR_FLOOR: decode = occ_pkg::REG_FLOOR;
      occ_pkg::ADR_CEIL: decode = occ_pkg::REG_CEIL;
      occ_pkg::ADR_CLAMP_LO: decode = occ_pkg::REG_CLAMP_LO;
      occ_pkg::ADR_CLAMP_HI: decode = occ_pkg::REG_CLAMP_HI;
      occ_pkg::ADR_STATUS: decode = occ_pkg::REG_STATUS;
      default: decode = occ_pkg::REG_NONE;
    endcase
  endfunction : decode

  // merge the two low byte lanes of a write into a 16-bit value
  // lanes two and three carry nothing for these registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = old;
    if (st[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (st[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction : merge16

  // merge byte lane 0 into an 8-bit value
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] st);
    merge8 = st[0] ? d[7:0] : old;
  endfunction : merge8

  // next state: bus handshakes, register writes and read data
  always_comb begin
    occ_pkg::occ_reg_t wsel;
    occ_pkg::occ_reg_t rsel;
    logic locked;
    logic [15:0] tmp;
    wsel = decode(s_r.aw_addr);
    rsel = decode(s_axi_araddr);
    locked = s_r.mode[occ_pkg::MODE_LOCK_BIT];
    tmp = 16'h0000;
    s_nxt = s_r;
    // level from an asynchronous pin, two flops before use
    s_nxt.fault_sync = {s_r.fault_sync[0], fault_in};
    // hold address and data until both are present
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // readies stay low while bvalid is up, so a held beat is kept
    // perform the write once address and data are both held
    if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = occ_pkg::RESP_OKAY;
      if (wsel == occ_pkg::REG_NONE || wsel == occ_pkg::REG_STATUS) begin
        s_nxt.bresp = occ_pkg::RESP_SLVERR;
      end else if (wsel == occ_pkg::REG_MODE) begin
        // lock bit stays writable so the lock can be lifted
        // bit 7 is masked off so it always reads zero
        s_nxt.mode = merge8(s_r.mode, s_r.w_data, s_r.w_strb)
                     & occ_pkg::MODE_WR_MASK;
      end else if (locked) begin
        // a locked write answers an error and changes nothing
        s_nxt.bresp = occ_pkg::RESP_SLVERR;
      end else begin
        case (wsel)
          occ_pkg::REG_FAULT: begin
            s_nxt.fault_hi = merge8(s_r.fault_hi, s_r.w_data,
                                    s_r.w_strb);
          end
          occ_pkg::REG_K0: begin
            s_nxt.k0_hi = merge8(s_r.k0_hi, s_r.w_data, s_r.w_strb);
          end
          occ_pkg::REG_K1: begin
            s_nxt.k1 = merge16(s_r.k1, s_r.w_data, s_r.w_strb);
          end
          occ_pkg::REG_K2: begin
            s_nxt.k2 = merge16(s_r.k2, s_r.w_data, s_r.w_strb);
          end
          occ_pkg::REG_M1: begin
            s_nxt.m1 = merge16(s_r.m1, s_r.w_data, s_r.w_strb);
          end
          occ_pkg::REG_FLOOR: begin
            // twelve-bit fields drop the top nibble of the write
            tmp = merge16({4'h0, s_r.floor_v}, s_r.w_data, s_r.w_strb);
            s_nxt.floor_v = tmp[11:0];
          end
          occ_pkg::REG_CEIL: begin
            tmp = merge16({4'h0, s_r.ceil_v}, s_r.w_data, s_r.w_strb);
            s_nxt.ceil_v = tmp[11:0];
          end
          occ_pkg::REG_CLAMP_LO: begin
            tmp = merge16({4'h0, s_r.clamp_lo}, s_r.w_data, s_r.w_strb);
            s_nxt.clamp_lo = tmp[11:0];
          end
          occ_pkg::REG_CLAMP_HI: begin
            tmp = merge16({4'h0, s_r.clamp_hi}, s_r.w_data, s_r.w_strb);
            s_nxt.clamp_hi = tmp[11:0];
          end
          default: begin
            s_nxt.bresp = occ_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    // read channel: answer one cycle after the address is taken
    // arready is low while rvalid is up, so one read is under way
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = occ_pkg::RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      case (rsel)
        occ_pkg::REG_MODE: s_nxt.rdata[7:0] = s_r.mode;
        occ_pkg::REG_FAULT: s_nxt.rdata[7:0] = s_r.fault_hi;
        occ_pkg::REG_K0: s_nxt.rdata[7:0] = s_r.k0_hi;
        occ_pkg::REG_K1: s_nxt.rdata[15:0] = s_r.k1;
        occ_pkg::REG_K2: s_nxt.rdata[15:0] = s_r.k2;
        occ_pkg::REG_M1: s_nxt.rdata[15:0] = s_r.m1;
        occ_pkg::REG_FLOOR: s_nxt.rdata[11:0] = s_r.floor_v;
        occ_pkg::REG_CEIL: s_nxt.rdata[11:0] = s_r.ceil_v;
        occ_pkg::REG_CLAMP_LO: s_nxt.rdata[11:0] = s_r.clamp_lo;
        occ_pkg::REG_CLAMP_HI: s_nxt.rdata[11:0] = s_r.clamp_hi;
        occ_pkg::REG_STATUS: begin
          // snapshot of the selector when the address is taken
          s_nxt.rdata[15:0] = out_code;
          s_nxt.rdata[occ_pkg::STAT_FAULT_BIT] = fault_active;
          s_nxt.rdata[occ_pkg::STAT_LOW_BIT] = below;
          s_nxt.rdata[occ_pkg::STAT_HIGH_BIT] = above;
        end
        default: s_nxt.rresp = occ_pkg::RESP_SLVERR;
      endcase
    end
  end

  // register all state; constants only under reset
  // settings get their reset values; the rest starts at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.mode <= occ_pkg::RST_BYTE;
      s_r.fault_hi <= occ_pkg::RST_BYTE;
      s_r.k0_hi <= occ_pkg::RST_BYTE;
      s_r.k1 <= occ_pkg::RST_COEF;
      s_r.k2 <= occ_pkg::RST_COEF;
      s_r.m1 <= occ_pkg::RST_COEF;
      s_r.floor_v <= occ_pkg::RST_FLOOR;
      s_r.ceil_v <= occ_pkg::RST_CEIL;
      s_r.clamp_lo <= occ_pkg::RST_CLAMP;
      s_r.clamp_hi <= occ_pkg::RST_CLAMP;
    end else begin
      s_r <= s_nxt;
    end
  end

  // bus handshake outputs
  // readies are combinational, so a request is taken the edge it meets
  assign s_axi_awready = !s_r.aw_held && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_held && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // mode outputs straight from the mode register
  // settings act on the outputs from the edge the write lands
  assign write_locked = s_r.mode[occ_pkg::MODE_LOCK_BIT];
  assign output_filter_cap_pin = s_r.mode[occ_pkg::MODE_CAP_BIT];
  assign analog_diag_global_on = s_r.mode[occ_pkg::MODE_DIAG_BIT];
  assign high_offset_lin = s_r.mode[occ_pkg::MODE_OFS_BIT];
  assign temp_source_current_setting =
    s_r.mode[occ_pkg::MODE_ITEMP_LSB +: 3];

  // coefficients; low byte of the first is fixed zero
  // the filter reads these levels directly; no shadow copy is kept
  assign lowpass_coef_k0 = {s_r.k0_hi, occ_pkg::FIXED_LOW_BYTE};
  assign lowpass_coef_k1 = s_r.k1;
  assign lowpass_coef_k2 = s_r.k2;
  assign lowpass_coef_m1 = s_r.m1;

  // output code selection with fault override and clamping
  // the fault level reaches the selector only after both sync flops
  occ_code_sel u_sel (
    .clk(clk),
    .rst(rst),
    .raw_code(raw_code),
    .fault(s_r.fault_sync[1]),
    .diag_on(s_r.mode[occ_pkg::MODE_DIAG_BIT]),
    .fault_hi(s_r.fault_hi),
    .range_floor(s_r.floor_v),
    .range_ceil(s_r.ceil_v),
    .clamp_lo(s_r.clamp_lo),
    .clamp_hi(s_r.clamp_hi),
    .out_code(out_code),
    .fault_active(fault_active),
    .below(below),
    .above(above)
  );

endmodule : occ_cfg

// ===== occ_pkg.sv
// constants, register map and field layout of the output clamp and
// fault configuration block; shared by the block and its code selector.
// assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
//
// Behaviour
// - lock bit 0 set refuses memory writes; the code still accepts writes to the mode register
// - bit 1 connects output filter capacitor pin
// - bit 2 enables all analog diagnostics globally
// - bit 3 selects high-offset linearization algorithm
// - bits 4 to 6 hold temperature current
// - diagnosed fault replaces code with fault code
// - fault code keeps upper byte, lower zero
// - first coefficient keeps upper byte, lower zero
// - coefficients two to four are full 16-bit
// - code below floor becomes lower clamp value
// - code above ceiling becomes upper clamp value
// - lower clamp value is 12-bit programmable field
// - upper clamp value is 12-bit programmable field
package occ_pkg;

  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_MODE = 32'h4000_0028;
  localparam logic [31:0] IDX_FAULT = 32'h4000_002A;
  localparam logic [31:0] IDX_K0 = 32'h4000_002B;
  localparam logic [31:0] IDX_K1 = 32'h4000_002C;
  localparam logic [31:0] IDX_K2 = 32'h4000_002E;
  localparam logic [31:0] IDX_M1 = 32'h4000_0030;
  localparam logic [31:0] IDX_FLOOR = 32'h4000_0032;
  localparam logic [31:0] IDX_CEIL = 32'h4000_0034;
  localparam logic [31:0] IDX_CLAMP_LO = 32'h4000_0036;
  localparam logic [31:0] IDX_CLAMP_HI = 32'h4000_0038;
  localparam logic [31:0] IDX_STATUS = 32'h4000_003C;

  // byte addresses, kept to the 32-bit bus width
  localparam logic [31:0] ADR_MODE = IDX_MODE << 2;
  localparam logic [31:0] ADR_FAULT = IDX_FAULT << 2;
  localparam logic [31:0] ADR_K0 = IDX_K0 << 2;
  localparam logic [31:0] ADR_K1 = IDX_K1 << 2;
  localparam logic [31:0] ADR_K2 = IDX_K2 << 2;
  localparam logic [31:0] ADR_M1 = IDX_M1 << 2;
  localparam logic [31:0] ADR_FLOOR = IDX_FLOOR << 2;
  localparam logic [31:0] ADR_CEIL = IDX_CEIL << 2;
  localparam logic [31:0] ADR_CLAMP_LO = IDX_CLAMP_LO << 2;
  localparam logic [31:0] ADR_CLAMP_HI = IDX_CLAMP_HI << 2;
  localparam logic [31:0] ADR_STATUS = IDX_STATUS << 2;

  // mode register field positions
  localparam int MODE_LOCK_BIT = 0;
  localparam int MODE_CAP_BIT = 1;
  localparam int MODE_DIAG_BIT = 2;
  localparam int MODE_OFS_BIT = 3;
  localparam int MODE_ITEMP_LSB = 4;
  localparam logic [7:0] MODE_WR_MASK = 8'h7F;

  // status register field positions
  localparam int STAT_FAULT_BIT = 16;
  localparam int STAT_LOW_BIT = 17;
  localparam int STAT_HIGH_BIT = 18;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COEF = 16'h0000;
  localparam logic [11:0] RST_FLOOR = 12'h000;
  localparam logic [11:0] RST_CEIL = 12'hFFF;
  localparam logic [11:0] RST_CLAMP = 12'h000;
  localparam logic [7:0] FIXED_LOW_BYTE = 8'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // register selected by an address
  typedef enum {
    REG_MODE, REG_FAULT, REG_K0, REG_K1, REG_K2, REG_M1, REG_FLOOR,
    REG_CEIL, REG_CLAMP_LO, REG_CLAMP_HI, REG_STATUS, REG_NONE
  } occ_reg_t;

endpackage : occ_pkg

// ===== occ_code_sel.sv
// output converter code selector: fault override, then range clamping.
// assumes raw_code and fault come from logic on the same clock.
`timescale 1ns/1ns
module occ_code_sel (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // incoming code and fault
  input wire logic [15:0] raw_code,
  input wire logic fault,
  // settings
  input wire logic diag_on,
  input wire logic [7:0] fault_hi,
  input wire logic [11:0] range_floor,
  input wire logic [11:0] range_ceil,
  input wire logic [11:0] clamp_lo,
  input wire logic [11:0] clamp_hi,
  // selected code and flags
  output logic [15:0] out_code,
  output logic fault_active,
  output logic below,
  output logic above
);

  typedef struct packed {
    logic [15:0] code;
    logic flt;
    logic lo;
    logic hi;
  } occ_sel_state_t;

  occ_sel_state_t s_r;
  occ_sel_state_t s_nxt;

  // pick the next code; fault first, then clamps, else pass through
  always_comb begin
    s_nxt.flt = diag_on & fault;
    s_nxt.lo = raw_code < {4'h0, range_floor};
    s_nxt.hi = raw_code > {4'h0, range_ceil};
    if (s_nxt.flt) begin
      s_nxt.code = {fault_hi, occ_pkg::FIXED_LOW_BYTE};
    end else if (s_nxt.lo) begin
      s_nxt.code = {4'h0, clamp_lo};
    end else if (s_nxt.hi) begin
      s_nxt.code = {4'h0, clamp_hi};
    end else begin
      s_nxt.code = raw_code;
    end
  end

  // register the selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_code = s_r.code;
  assign fault_active = s_r.flt;
  assign below = s_r.lo;
  assign above = s_r.hi;

endmodule : occ_code_sel

// ===== occ_cfg_assertions.sv
// checker of the configuration block: bus timing, lock, mode, fault code.
// assumes it is bound to occ_cfg and sees only that module's ports.
`timescale 1ns/1ns
module occ_cfg_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // output path and settings
  input wire logic fault_in,
  input wire logic [15:0] out_code,
  input wire logic write_locked,
  input wire logic output_filter_cap_pin,
  input wire logic analog_diag_global_on,
  input wire logic high_offset_lin,
  input wire logic [2:0] temp_source_current_setting,
  input wire logic [15:0] lowpass_coef_k0,
  input wire logic [15:0] lowpass_coef_k1
);
  logic [6:0] mode_w;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // all mode outputs as one bundle
  assign mode_w = {temp_source_current_setting, high_offset_lin,
    analog_diag_global_on, output_filter_cap_pin, write_locked};

  // properties and their assertions
  property p_lock_hold;
    write_locked && $past(write_locked) |-> $stable(lowpass_coef_k1);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("coefficient changed while locked");
  property p_k0_low;
    lowpass_coef_k0[7:0] == 8'h00;
  endproperty
  a_k0_low: assert property (p_k0_low)
    else $error("first coefficient low byte not zero");
  property p_mode_src;
    $changed(mode_w) |-> $rose(s_axi_bvalid);
  endproperty
  a_mode_src: assert property (p_mode_src)
    else $error("mode output changed without a write");
  property p_fault_code;
    (analog_diag_global_on && fault_in) [*4] |=> out_code[7:0] == 8'h00;
  endproperty
  a_fault_code: assert property (p_fault_code)
    else $error("fault code low byte not zero");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_ar_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_ans: assert property (p_ar_ans)
    else $error("read answer late");
  property p_w_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_w_ans: assert property (p_w_ans)
    else $error("write answer late");
endmodule : occ_cfg_chk

bind occ_cfg occ_cfg_chk chk_u (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .fault_in, .out_code, .write_locked, .output_filter_cap_pin,
  .analog_diag_global_on, .high_offset_lin, .temp_source_current_setting,
  .lowpass_coef_k0, .lowpass_coef_k1);

// ===== occ_cfg_test.sv
// self-checking bench of the configuration block over its register bus.
// assumes status returns flags and the selected code of the output path.
`timescale 1ns/1ns
module occ_cfg_test;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, fault_in, write_locked, high_offset_lin;
  logic output_filter_cap_pin, analog_diag_global_on;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rnd, e;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] temp_source_current_setting;
  logic [15:0] raw_code, out_code, lowpass_coef_k0, lowpass_coef_k1;
  logic [15:0] lowpass_coef_k2, lowpass_coef_m1;
  logic [33:0] q[$];
  logic [31:0] adr[9];
  logic [15:0] msk[9], rv[9], cur[9], cd[6];
  int errors, checked;
  localparam logic [1:0] ER = occ_pkg::RESP_SLVERR;

  occ_cfg dut_u (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .raw_code, .fault_in, .out_code, .write_locked, .output_filter_cap_pin,
    .analog_diag_global_on, .high_offset_lin, .temp_source_current_setting,
    .lowpass_coef_k0, .lowpass_coef_k1, .lowpass_coef_k2, .lowpass_coef_m1);

  // clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // status word for a raw code with the settings of the output test
  function automatic logic [31:0] stat(input logic [15:0] r, input bit f);
    logic lo, hi;
    logic [15:0] c;
    lo = r < 16'h0100;
    hi = r > 16'h0E00;
    c = f ? 16'hC300 : lo ? 16'h0055 : hi ? 16'h0AAA : r;
    return {13'h0, hi, lo, f, c};
  endfunction : stat

  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // one bus transfer; the expected answer goes to the queue first
  task automatic bus(input bit w, input logic [31:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    int n;
    q.push_back(x);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      errors++;
      close_out();
    end
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bus(1'b1, a, d, {r, 32'h0});
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] d);
    bus(1'b0, a, 32'h0, {2'b00, d});
  endtask : rd

  // compare each bus answer with the oldest note
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      cmp({s_axi_bresp, 32'h0}, q.pop_front());
    end
    if (s_axi_rvalid && s_axi_rready) begin
      cmp({s_axi_rresp, s_axi_rdata}, q.pop_front());
    end
  end

  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, fault_in, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {raw_code, errors, checked} = '0;
    s_axi_wstrb = 4'hF;
    rnd = 32'h3661F25B;
    rst = 1'b1;
    adr = '{occ_pkg::ADR_FAULT, occ_pkg::ADR_K0, occ_pkg::ADR_K1,
      occ_pkg::ADR_K2, occ_pkg::ADR_M1, occ_pkg::ADR_FLOOR, occ_pkg::ADR_CEIL,
      occ_pkg::ADR_CLAMP_LO, occ_pkg::ADR_CLAMP_HI};
    msk = '{16'h00FF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0FFF,
      16'h0FFF, 16'h0FFF, 16'h0FFF};
    rv = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0FFF, 16'h0, 16'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values of every register except status
    rd(occ_pkg::ADR_MODE, 32'h0);
    for (int i = 0; i < 9; i++) rd(adr[i], rv[i]);
    $display("test reset done");
    // random write and read back, with the coefficient ports
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      cur[i] = rnd[15:0] & msk[i];
      wr(adr[i], rnd, 2'b00);
      rd(adr[i], cur[i]);
    end
    cmp(lowpass_coef_k0, {cur[1][7:0], 8'h00});
    cmp(lowpass_coef_m1, cur[4]);
    cmp(lowpass_coef_k1, cur[2]);
    cmp(lowpass_coef_k2, cur[3]);
    $display("test storage done");
    // each mode bit alone, bit 7 reserved
    for (int i = 0; i < 8; i++) begin
      wr(occ_pkg::ADR_MODE, 32'h1 << i, 2'b00);
      rd(occ_pkg::ADR_MODE, (32'h1 << i) & 32'h7F);
      cmp({temp_source_current_setting, high_offset_lin, analog_diag_global_on,
        output_filter_cap_pin, write_locked}, (8'h1 << i) & 8'h7F);
    end
    $display("test mode done");
    // lock refuses writes; unmapped and status places refuse
    wr(occ_pkg::ADR_MODE, 32'h1, 2'b00);
    wr(adr[2], 32'h1234, ER);
    rd(adr[2], cur[2]);
    cmp(lowpass_coef_k1, cur[2]);
    wr(occ_pkg::ADR_MODE, 32'h0, 2'b00);
    wr(adr[2], 32'h1234, 2'b00);
    rd(adr[2], 32'h1234);
    cmp(lowpass_coef_k1, 16'h1234);
    bus(1'b0, 32'h4, 32'h0, {ER, 32'h0});
    wr(32'h4, 32'h0, ER);
    wr(occ_pkg::ADR_STATUS, 32'h0, ER);
    $display("test lock done");
    // output path: clamps, fault code and their priority
    wr(adr[0], 32'hC3, 2'b00);
    wr(adr[5], 32'h100, 2'b00);
    wr(adr[6], 32'hE00, 2'b00);
    wr(adr[7], 32'h055, 2'b00);
    wr(adr[8], 32'hAAA, 2'b00);
    cd = '{16'h00FF, 16'h0100, 16'h0E00, 16'h0E01, 16'hFFFF, 16'h0};
    for (int m = 0; m < 3; m++) begin
      wr(occ_pkg::ADR_MODE, (m == 2) ? 32'h0 : 32'h4, 2'b00);
      fault_in <= (m > 0);
      for (int i = 0; i < 6; i++) begin
        rnd = lfsr(rnd);
        if (i == 5) cd[5] = rnd[15:0];
        raw_code <= cd[i];
        repeat (5) @(posedge clk);
        e = stat(cd[i], m == 1);
        cmp(out_code, e[15:0]);
        rd(occ_pkg::ADR_STATUS, e);
      end
    end
    $display("test output done");
    close_out();
  end
endmodule : occ_cfg_test
